//--- rtl/fault_supervisor.sv
// Current and temperature fault supervisor with shutdown and retry reactions per temperature fault
// Function
// - Compare samples against peak overcurrent threshold word.
// - Compare samples against valley undercurrent threshold word.
// - Ignore current samples taken during blanking.
// - Current fault after N consecutive exceeding samples.
// - Hot fault when temperature above fault limit.
// - Hot fault holds until below warning limit.
// - Hot warning sets summary, warning bit, alert.
// - Cold warning sets summary, warning bit, alert.
// - Cold fault when temperature below fault limit.
// - Cold fault holds until above warning limit.
// - Thresholds are words, reactions are bytes.
// - Reaction bytes reset to immediate off, no retry.
// - Fault bits sticky until clear command.
// - Mode 00 keeps output running, records fault.
// - Mode 01 delays, disables, then retries.
// - Mode 10 disables at once, then retries.
// - Mode 11 disables only while fault persists.
// - Retry 000 stays off until restart.
// - Retry 1..6 limits attempts, spaced by time.
// - Retry 111 restarts forever without checking.
// - Time field sets delay and retry spacing.
module fault_supervisor
  import fault_supervisor_pkg::*;
#(
  parameter int unsigned HOT_UNIT_CYCLES  = HOT_UNIT_US * 1000 / CLK_PERIOD_NS,
  parameter int unsigned COLD_UNIT_CYCLES = COLD_UNIT_US * 1000 / CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Command port
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic        CMD_WR,
  input  wire logic [15:0] CMD_WDATA,
  input  wire logic        CMD_RD,
  output logic      [15:0] RD_DATA,
  output logic             RD_VALID,
  output logic             RD_MISS,
  // Inductor current samples
  input  wire logic        IL_VALID,
  input  wire logic        IL_BLANKING,
  input  wire logic [15:0] IL_SAMPLE,
  input  wire logic [3:0]  CONSEC_SAMPLES,
  // Temperature samples
  input  wire logic        TEMP_VALID,
  input  wire logic [15:0] TEMP_SAMPLE,
  // Power stage control
  input  wire logic        ENABLE,
  input  wire logic        RESTART,
  output logic             OUT_EN,
  output logic             ALERT_N
);

  localparam int unsigned NCH = 2;

  logic [15:0] overcurrent_fault_threshold;
  logic [15:0] undercurrent_fault_threshold;
  logic [15:0] hot_fault_threshold;
  logic [15:0] hot_warning_threshold;
  logic [15:0] cold_warning_threshold;
  logic [15:0] cold_fault_threshold;
  logic [7:0]  hot_fault_reaction;
  logic [7:0]  cold_fault_reaction;

  logic        clear_cmd;
  logic [7:0]  status_temp;
  logic [7:0]  status_cur;
  logic [15:0] status_sum;

  logic [3:0]  oc_run;
  logic [3:0]  uc_run;
  logic        oc_hit;
  logic        uc_hit;
  logic        hot_active;
  logic        cold_active;
  logic        hot_warn;
  logic        cold_warn;

  logic [NCH-1:0] ch_active;
  logic [NCH-1:0] ch_allow;
  logic [7:0]     ch_react [NCH];
  logic [31:0]    ch_unit  [NCH];

  // Mantissa shifted by exponent into one common fixed-point scale
  function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0]         sh;
    m = {{37{w[LIN_MANT_MSB]}}, w[LIN_MANT_MSB:0]};
    // Exponent biased by sixteen, so the shift is never negative
    sh = {~w[LIN_EXP_MSB], w[LIN_EXP_MSB-1:LIN_EXP_LSB]};
    return m <<< sh;
  endfunction

  logic signed [47:0] il_fix;
  logic signed [47:0] temp_fix;
  logic               il_over;
  logic               il_under;
  logic               t_above_hot_fault;
  logic               t_below_hot_warn;
  logic               t_above_hot_warn;
  logic               t_below_cold_fault;
  logic               t_above_cold_warn;
  logic               t_below_cold_warn;

  always_comb begin
    il_fix   = lin_to_fix(IL_SAMPLE);
    temp_fix = lin_to_fix(TEMP_SAMPLE);
    il_over  = il_fix > lin_to_fix(overcurrent_fault_threshold);
    il_under = il_fix < lin_to_fix(undercurrent_fault_threshold);
    t_above_hot_fault  = temp_fix > lin_to_fix(hot_fault_threshold);
    t_above_hot_warn   = temp_fix > lin_to_fix(hot_warning_threshold);
    t_below_hot_warn   = temp_fix < lin_to_fix(hot_warning_threshold);
    t_below_cold_fault = temp_fix < lin_to_fix(cold_fault_threshold);
    t_below_cold_warn  = temp_fix < lin_to_fix(cold_warning_threshold);
    t_above_cold_warn  = temp_fix > lin_to_fix(cold_warning_threshold);
  end

  // Settings, written by word or by byte
  // Byte settings keep the low half; the upper half is dropped
  always_ff @(posedge CLK) begin
    if (SRST) begin
      overcurrent_fault_threshold  <= RST_OVERCURRENT_FAULT_THRESHOLD;
      undercurrent_fault_threshold <= RST_UNDERCURRENT_FAULT_THRESHOLD;
      hot_fault_threshold          <= RST_HOT_FAULT_THRESHOLD;
      hot_warning_threshold        <= RST_HOT_WARNING_THRESHOLD;
      cold_warning_threshold       <= RST_COLD_WARNING_THRESHOLD;
      cold_fault_threshold         <= RST_COLD_FAULT_THRESHOLD;
      hot_fault_reaction           <= RST_FAULT_REACTION;
      cold_fault_reaction          <= RST_FAULT_REACTION;
    end else if (CMD_WR) begin
      case (CMD_CODE)
        CODE_OVERCURRENT_FAULT_THRESHOLD:  overcurrent_fault_threshold  <= CMD_WDATA;
        CODE_UNDERCURRENT_FAULT_THRESHOLD: undercurrent_fault_threshold <= CMD_WDATA;
        CODE_HOT_FAULT_THRESHOLD:          hot_fault_threshold          <= CMD_WDATA;
        CODE_HOT_WARNING_THRESHOLD:        hot_warning_threshold        <= CMD_WDATA;
        CODE_COLD_WARNING_THRESHOLD:       cold_warning_threshold       <= CMD_WDATA;
        CODE_COLD_FAULT_THRESHOLD:         cold_fault_threshold         <= CMD_WDATA;
        CODE_HOT_FAULT_REACTION:           hot_fault_reaction           <= CMD_WDATA[7:0];
        CODE_COLD_FAULT_REACTION:          cold_fault_reaction          <= CMD_WDATA[7:0];
        default: ;
      endcase
    end
  end

  assign clear_cmd = CMD_WR && (CMD_CODE == CODE_FAULT_FLAG_CLEAR_COMMAND);

  // Read answer, one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RD_DATA  <= 16'h0000;
      RD_VALID <= 1'b0;
      RD_MISS  <= 1'b0;
    end else begin
      RD_VALID <= CMD_RD;
      RD_MISS  <= 1'b0;
      if (CMD_RD) begin
        case (CMD_CODE)
          CODE_OVERCURRENT_FAULT_THRESHOLD:  RD_DATA <= overcurrent_fault_threshold;
          CODE_UNDERCURRENT_FAULT_THRESHOLD: RD_DATA <= undercurrent_fault_threshold;
          CODE_HOT_FAULT_THRESHOLD:          RD_DATA <= hot_fault_threshold;
          CODE_HOT_WARNING_THRESHOLD:        RD_DATA <= hot_warning_threshold;
          CODE_COLD_WARNING_THRESHOLD:       RD_DATA <= cold_warning_threshold;
          CODE_COLD_FAULT_THRESHOLD:         RD_DATA <= cold_fault_threshold;
          CODE_HOT_FAULT_REACTION:           RD_DATA <= {8'h00, hot_fault_reaction};
          CODE_COLD_FAULT_REACTION:          RD_DATA <= {8'h00, cold_fault_reaction};
          CODE_STATUS_SUMMARY:               RD_DATA <= status_sum;
          CODE_STATUS_CURRENT:               RD_DATA <= {8'h00, status_cur};
          CODE_STATUS_TEMPERATURE:           RD_DATA <= {8'h00, status_temp};
          // Unknown code answers zero and flags a miss
          default: begin
            RD_DATA <= 16'h0000;
            RD_MISS <= 1'b1;
          end
        endcase
      end
    end
  end

  // Consecutive sample qualifiers; a count of zero acts as one
  logic [3:0] need;
  assign need = (CONSEC_SAMPLES == 4'h0) ? 4'h1 : CONSEC_SAMPLES;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      oc_run <= 4'h0;
      uc_run <= 4'h0;
    end else if (IL_VALID && !IL_BLANKING) begin
      // Saturate, so a long excursion never wraps back to zero
      oc_run <= !il_over ? 4'h0 : (oc_run == 4'hf) ? oc_run : oc_run + 4'h1;
      uc_run <= !il_under ? 4'h0 : (uc_run == 4'hf) ? uc_run : uc_run + 4'h1;
    end
  end

  assign oc_hit = (oc_run >= need);
  assign uc_hit = (uc_run >= need);

  // Temperature conditions, with hysteresis on the faults
  // Warnings are plain levels of the last sample; status latches them
  always_ff @(posedge CLK) begin
    if (SRST) begin
      hot_active  <= 1'b0;
      cold_active <= 1'b0;
      hot_warn    <= 1'b0;
      cold_warn   <= 1'b0;
    end else if (TEMP_VALID) begin
      if (t_above_hot_fault)
        hot_active <= 1'b1;
      else if (t_below_hot_warn)
        hot_active <= 1'b0;
      if (t_below_cold_fault)
        cold_active <= 1'b1;
      else if (t_above_cold_warn)
        cold_active <= 1'b0;
      hot_warn  <= t_above_hot_warn;
      cold_warn <= t_below_cold_warn;
    end
  end

  // Sticky status; a condition present in the clear cycle wins
  always_ff @(posedge CLK) begin
    if (SRST) begin
      status_temp <= 8'h00;
      status_cur  <= 8'h00;
    end else begin
      if (clear_cmd) begin
        status_temp <= 8'h00;
        status_cur  <= 8'h00;
      end
      if (hot_active)
        status_temp[TEMP_HOT_FAULT_BIT] <= 1'b1;
      if (cold_active)
        status_temp[TEMP_COLD_FAULT_BIT] <= 1'b1;
      if (hot_warn)
        status_temp[TEMP_HOT_WARN_BIT] <= 1'b1;
      if (cold_warn)
        status_temp[TEMP_COLD_WARN_BIT] <= 1'b1;
      if (oc_hit)
        status_cur[CUR_OVER_FAULT_BIT] <= 1'b1;
      if (uc_hit)
        status_cur[CUR_UNDER_FAULT_BIT] <= 1'b1;
    end
  end

  always_comb begin
    status_sum                      = 16'h0000;
    status_sum[SUM_TEMPERATURE_BIT] = |status_temp;
    status_sum[SUM_CURRENT_BIT]     = |status_cur;
    status_sum[SUM_OFF_BIT]         = !OUT_EN;
  end

  // Alert is a level held until every sticky bit is cleared
  always_ff @(posedge CLK) begin
    if (SRST)
      ALERT_N <= 1'b1;
    else
      ALERT_N <= !((|status_temp) || (|status_cur));
  end

  assign ch_active[0] = hot_active;
  assign ch_active[1] = cold_active;
  assign ch_react[0]  = hot_fault_reaction;
  assign ch_react[1]  = cold_fault_reaction;
  // Time units per fault type; shortened by parameter in simulation
  assign ch_unit[0]   = HOT_UNIT_CYCLES;
  assign ch_unit[1]   = COLD_UNIT_CYCLES;

  // Reaction engine per temperature fault
  for (genvar c = 0; c < NCH; c++) begin : g_react
    react_state_t state;
    react_mode_t  mode;
    logic [2:0]   retry;
    logic [2:0]   tcount;
    logic [2:0]   units;
    logic [31:0]  cyc;
    logic [2:0]   attempts;
    logic         done;

    assign mode   = react_mode_t'(ch_react[c][REACT_MODE_MSB:REACT_MODE_LSB]);
    assign retry  = ch_react[c][REACT_RETRY_MSB:REACT_RETRY_LSB];
    assign tcount = ch_react[c][REACT_TIME_MSB:0];
    assign done   = (units == 3'h0) && (cyc == 32'h0);

    always_ff @(posedge CLK) begin
      if (SRST || !ENABLE || RESTART) begin
        state    <= ST_RUN;
        units    <= 3'h0;
        cyc      <= 32'h0;
        attempts <= 3'h0;
      end else begin
        if (cyc != 32'h0)
          cyc <= cyc - 32'h1;
        else if (units != 3'h0) begin
          units <= units - 3'h1;
          cyc   <= ch_unit[c] - 32'h1;
        end
        // Mode is read only in run; a new setting waits for the next trip
        case (state)
          ST_RUN: begin
            if (ch_active[c]) begin
              case (mode)
                MODE_IGNORE: state <= ST_RUN;
                MODE_DELAY: begin
                  state <= ST_DELAY;
                  units <= tcount;
                  cyc   <= 32'h0;
                end
                MODE_OFF:    state <= ST_OFF;
                MODE_FOLLOW: state <= ST_HOLD;
                default:     state <= ST_RUN;
              endcase
            end
          end
          ST_DELAY: begin
            if (done)
              state <= ST_OFF;
          end
          ST_OFF: begin
            if (retry == RETRY_NONE)
              state <= ST_LOCK;
            else if (retry != RETRY_FOREVER && attempts >= retry)
              state <= ST_LOCK;
            else begin
              state <= ST_GAP;
              units <= tcount;
              cyc   <= 32'h0;
            end
          end
          ST_GAP: begin
            if (done) begin
              // Back to run even if the fault stands; it trips again
              state <= ST_RUN;
              if (retry != RETRY_FOREVER)
                attempts <= attempts + 3'h1;
            end
          end
          ST_HOLD: begin
            if (!ch_active[c])
              state <= ST_RUN;
          end
          // Only reset, restart or enable low leaves the lock
          ST_LOCK: state <= ST_LOCK;
          default: state <= ST_RUN;
        endcase
      end
    end

    // Output allowed only while running, delaying, or ignoring
    assign ch_allow[c] = (state == ST_RUN) || (state == ST_DELAY);
  end

  always_ff @(posedge CLK) begin
    if (SRST)
      OUT_EN <= 1'b0;
    else
      OUT_EN <= ENABLE && (&ch_allow);
  end

endmodule // fault_supervisor

//--- rtl/fault_supervisor_pkg.sv
// Constants, command codes and types for the current and temperature fault supervisor
package fault_supervisor_pkg;

  // Clock
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Command codes of the threshold and reaction settings
  localparam logic [7:0] CODE_OVERCURRENT_FAULT_THRESHOLD  = 8'h46;
  localparam logic [7:0] CODE_UNDERCURRENT_FAULT_THRESHOLD = 8'h4b;
  localparam logic [7:0] CODE_HOT_FAULT_THRESHOLD          = 8'h4f;
  localparam logic [7:0] CODE_HOT_FAULT_REACTION           = 8'h50;
  localparam logic [7:0] CODE_HOT_WARNING_THRESHOLD        = 8'h51;
  localparam logic [7:0] CODE_COLD_WARNING_THRESHOLD       = 8'h52;
  localparam logic [7:0] CODE_COLD_FAULT_THRESHOLD         = 8'h53;
  localparam logic [7:0] CODE_COLD_FAULT_REACTION          = 8'h54;

  // Command codes of the status words and the clear command
  localparam logic [7:0] CODE_FAULT_FLAG_CLEAR_COMMAND = 8'h03;
  localparam logic [7:0] CODE_STATUS_SUMMARY           = 8'h79;
  localparam logic [7:0] CODE_STATUS_CURRENT           = 8'h7b;
  localparam logic [7:0] CODE_STATUS_TEMPERATURE       = 8'h7d;

  // Reset values
  localparam logic [15:0] RST_OVERCURRENT_FAULT_THRESHOLD  = 16'hd340;
  localparam logic [15:0] RST_UNDERCURRENT_FAULT_THRESHOLD = 16'hd4c0;
  localparam logic [15:0] RST_HOT_FAULT_THRESHOLD          = 16'hebe8;
  localparam logic [15:0] RST_HOT_WARNING_THRESHOLD        = 16'heb70;
  localparam logic [15:0] RST_COLD_WARNING_THRESHOLD       = 16'he580;
  localparam logic [15:0] RST_COLD_FAULT_THRESHOLD         = 16'he490;
  localparam logic [7:0]  RST_FAULT_REACTION               = 8'h80;

  // Linear eleven format field positions
  localparam int unsigned LIN_EXP_MSB  = 15;
  localparam int unsigned LIN_EXP_LSB  = 11;
  localparam int unsigned LIN_MANT_MSB = 10;

  // Reaction byte fields
  localparam int unsigned REACT_MODE_MSB  = 7;
  localparam int unsigned REACT_MODE_LSB  = 6;
  localparam int unsigned REACT_RETRY_MSB = 5;
  localparam int unsigned REACT_RETRY_LSB = 3;
  localparam int unsigned REACT_TIME_MSB  = 2;
  localparam logic [2:0]  RETRY_NONE      = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER   = 3'h7;

  // Status bit positions
  localparam int unsigned TEMP_HOT_FAULT_BIT   = 7;
  localparam int unsigned TEMP_HOT_WARN_BIT    = 6;
  localparam int unsigned TEMP_COLD_WARN_BIT   = 5;
  localparam int unsigned TEMP_COLD_FAULT_BIT  = 4;
  localparam int unsigned CUR_OVER_FAULT_BIT   = 7;
  localparam int unsigned CUR_UNDER_FAULT_BIT  = 6;
  localparam int unsigned SUM_CURRENT_BIT      = 4;
  localparam int unsigned SUM_TEMPERATURE_BIT  = 2;
  localparam int unsigned SUM_OFF_BIT          = 6;

  // Retry and delay time units, per fault type
  localparam int unsigned HOT_UNIT_US  = 1000;
  localparam int unsigned COLD_UNIT_US = 1000;

  typedef enum logic [1:0] {
    MODE_IGNORE = 2'h0,
    MODE_DELAY  = 2'h1,
    MODE_OFF    = 2'h2,
    MODE_FOLLOW = 2'h3
  } react_mode_t;

  // Gray codes along run, delay, off, gap
  typedef enum logic [2:0] {
    ST_RUN   = 3'h0,
    ST_DELAY = 3'h1,
    ST_OFF   = 3'h3,
    ST_GAP   = 3'h2,
    ST_HOLD  = 3'h6,
    ST_LOCK  = 3'h7
  } react_state_t;

endpackage

//--- tb/fault_supervisor_sva.sv
// Port-level assertions for the fault supervisor
module fault_supervisor_sva (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // Command port
  input wire logic [7:0]  CMD_CODE,
  input wire logic        CMD_WR,
  input wire logic        CMD_RD,
  input wire logic [15:0] RD_DATA,
  input wire logic        RD_VALID,
  input wire logic        RD_MISS,
  // Samples and output stage
  input wire logic        IL_VALID,
  input wire logic        TEMP_VALID,
  input wire logic        ENABLE,
  input wire logic        OUT_EN,
  input wire logic        ALERT_N
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] since_smp;
  logic [3:0] since_clr;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // Saturating ages, so a stale event never looks fresh after a wrap
  always_ff @(posedge CLK) begin
    if (SRST) since_smp <= 4'hf;
    else if (IL_VALID || TEMP_VALID) since_smp <= 4'h0;
    else if (since_smp != 4'hf) since_smp <= since_smp + 4'h1;
  end
  always_ff @(posedge CLK) begin
    if (SRST) since_clr <= 4'hf;
    else if (CMD_WR && CMD_CODE == 8'h03) since_clr <= 4'h0;
    else if (since_clr != 4'hf) since_clr <= since_clr + 4'h1;
  end
  property p_reset_quiet;
    disable iff (1'b0) SRST |=> !OUT_EN && ALERT_N && !RD_VALID && !RD_MISS;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
  property p_rd_answer;
    CMD_RD |=> RD_VALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_quiet;
    !CMD_RD |=> !RD_VALID;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("answer without read");
  property p_rd_hold;
    !RD_VALID |-> $stable(RD_DATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_miss;
    RD_MISS |-> RD_VALID && RD_DATA == 16'h0000;
  endproperty
  a_miss: assert property (p_miss) else $error("bad miss answer");
  property p_byte_read;
    RD_VALID && $past(CMD_CODE) inside {8'h50, 8'h54} |-> RD_DATA[15:8] == 8'h00;
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("byte upper half set");
  property p_en_off;
    !ENABLE |=> !OUT_EN;
  endproperty
  a_en_off: assert property (p_en_off) else $error("output on while disabled");
  property p_out_rise;
    $rose(OUT_EN) |-> $past(ENABLE);
  endproperty
  a_out_rise: assert property (p_out_rise) else $error("output rose unenabled");
  property p_alert_fall;
    $fell(ALERT_N) |-> since_smp <= 4'h5;
  endproperty
  a_alert_fall: assert property (p_alert_fall) else $error("alert without sample");
  property p_alert_rise;
    $rose(ALERT_N) |-> since_clr <= 4'h3;
  endproperty
  a_alert_rise: assert property (p_alert_rise) else $error("alert left unbidden");
endmodule // fault_supervisor_sva

bind fault_supervisor fault_supervisor_sva i_sva (
  .CLK, .SRST, .CMD_CODE, .CMD_WR, .CMD_RD, .RD_DATA, .RD_VALID, .RD_MISS,
  .IL_VALID, .TEMP_VALID, .ENABLE, .OUT_EN, .ALERT_N
);

//--- tb/host_model.sv
// Host controller model that writes settings and reads status over the command port
module host_model (
  // Clock
  input  wire logic        CLK,
  // Command port
  output logic      [7:0]  CMD_CODE,
  output logic             CMD_WR,
  output logic      [15:0] CMD_WDATA,
  output logic             CMD_RD,
  input  wire logic [15:0] RD_DATA,
  input  wire logic        RD_VALID,
  input  wire logic        RD_MISS
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    CMD_CODE  = 8'h00;
    CMD_WR    = 1'b0;
    CMD_WDATA = 16'h0000;
    CMD_RD    = 1'b0;
  end
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge CLK);
    CMD_WR    <= 1'b1;
    CMD_CODE  <= code;
    CMD_WDATA <= data;
    @(posedge CLK);
    // Idle lines carry junk so a stale code is never mistaken for a request
    CMD_WR    <= 1'b0;
    CMD_CODE  <= ~code;
    CMD_WDATA <= ~data;
  endtask
  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic miss);
    int n;
    @(posedge CLK);
    CMD_RD   <= 1'b1;
    CMD_CODE <= code;
    @(posedge CLK);
    CMD_RD   <= 1'b0;
    CMD_CODE <= ~code;
    #1;
    for (n = 0; n < 4 && RD_VALID !== 1'b1; n++) begin
      @(posedge CLK);
      #1;
    end
    data = RD_DATA;
    miss = RD_MISS;
  endtask
endmodule // host_model

//--- tb/tb.sv
// Self-checking bench for the fault supervisor with a behavioural status model
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb import fault_supervisor_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  CODES [8] = '{8'h46, 8'h4b, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54};
  localparam logic [15:0] DEFS [8] = '{16'hd340, 16'hd4c0, 16'hebe8, 16'h0080,
                                      16'heb70, 16'he580, 16'he490, 16'h0080};
  localparam int          IL_SEQ [6] = '{14, 14, 0, 14, 14, 14};
  logic        CLK = 1'b0, SRST = 1'b1, CMD_WR, CMD_RD, RD_VALID, RD_MISS, OUT_EN, ALERT_N;
  logic [7:0]  CMD_CODE;
  logic [15:0] CMD_WDATA, RD_DATA, d;
  logic        IL_VALID = 1'b0, IL_BLANKING = 1'b0, TEMP_VALID = 1'b0, m;
  logic        ENABLE = 1'b0, RESTART = 1'b0;
  logic [15:0] IL_SAMPLE = 16'h0000, TEMP_SAMPLE = 16'h0000;
  logic [3:0]  CONSEC_SAMPLES = 4'h3;
  logic [31:0] seed = 32'hc8ef;
  logic [15:0] regs [logic [7:0]];
  int          n_errors = 0, comparisons = 0, k = 0;
  int          ms_temp = 0, ms_cur = 0, hot_act = 0, cold_act = 0;
  int          hot_lv = 0, cold_lv = 0, n_oc = 0, n_uc = 0;

  fault_supervisor #(.HOT_UNIT_CYCLES(4), .COLD_UNIT_CYCLES(4)) i_dut (
    .CLK, .SRST, .CMD_CODE, .CMD_WR, .CMD_WDATA, .CMD_RD, .RD_DATA, .RD_VALID, .RD_MISS,
    .IL_VALID, .IL_BLANKING, .IL_SAMPLE, .CONSEC_SAMPLES, .TEMP_VALID, .TEMP_SAMPLE,
    .ENABLE, .RESTART, .OUT_EN, .ALERT_N);
  host_model i_host (.CLK, .CMD_CODE, .CMD_WR, .CMD_WDATA, .CMD_RD, .RD_DATA, .RD_VALID,
    .RD_MISS);

  initial begin
    forever #(CLK_PERIOD_NS / 2) CLK = ~CLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic longint lin_value(input logic [15:0] w);
    int e;
    e = $signed(w[15:11]);
    return e < 0 ? (longint'($signed(w[10:0])) <<< 20) >>> -e
                 : longint'($signed(w[10:0])) <<< (20 + e);
  endfunction
  function automatic logic [15:0] tw(input int deg);
    return {5'h1d, 11'(deg * 8)};
  endfunction
  function automatic logic [15:0] iw(input int amp);
    return {5'h1a, 11'(amp * 64)};
  endfunction
  task automatic set(input logic [7:0] code, input logic [15:0] v);
    i_host.wr(code, v);
    regs[code] = code inside {8'h50, 8'h54} ? {8'h00, v[7:0]} : v;
  endtask
  task automatic clr;
    i_host.wr(8'h03, 16'h0000);
    ms_temp = hot_act << 7 | hot_lv << 6 | cold_lv << 5 | cold_act << 4;
    ms_cur = 0;
  endtask
  task automatic temp(input int deg);
    longint v;
    v = lin_value(tw(deg));
    @(posedge CLK);
    TEMP_VALID  <= 1'b1;
    TEMP_SAMPLE <= tw(deg);
    @(posedge CLK);
    TEMP_VALID  <= 1'b0;
    TEMP_SAMPLE <= seed[15:0];
    seed = lfsr(seed);
    if (v > lin_value(regs[8'h4f])) hot_act = 1;
    else if (v < lin_value(regs[8'h51])) hot_act = 0;
    if (v < lin_value(regs[8'h53])) cold_act = 1;
    else if (v > lin_value(regs[8'h52])) cold_act = 0;
    hot_lv = v > lin_value(regs[8'h51]);
    cold_lv = v < lin_value(regs[8'h52]);
    ms_temp |= hot_act << 7 | hot_lv << 6 | cold_lv << 5 | cold_act << 4;
    repeat (4) @(posedge CLK);
  endtask
  task automatic il(input int amp, input logic blank);
    longint v;
    v = lin_value(iw(amp));
    @(posedge CLK);
    IL_VALID    <= 1'b1;
    IL_BLANKING <= blank;
    IL_SAMPLE   <= iw(amp);
    @(posedge CLK);
    IL_VALID    <= 1'b0;
    IL_BLANKING <= seed[0];
    IL_SAMPLE   <= seed[31:16];
    seed = lfsr(seed);
    if (!blank) begin
      n_oc = v > lin_value(regs[8'h46]) ? n_oc + 1 : 0;
      n_uc = v < lin_value(regs[8'h4b]) ? n_uc + 1 : 0;
    end
    if (n_oc >= CONSEC_SAMPLES) ms_cur |= 8'h80;
    if (n_uc >= CONSEC_SAMPLES) ms_cur |= 8'h40;
    repeat (3) @(posedge CLK);
  endtask
  task automatic chk_status;
    i_host.rd(8'h7d, d, m);
    `CHK(d & 16'h00f0, 16'(ms_temp))
    i_host.rd(8'h7b, d, m);
    `CHK(d & 16'h00c0, 16'(ms_cur))
    i_host.rd(8'h79, d, m);
    `CHK(d & 16'h0014, {11'h0, ms_cur != 0, 1'b0, ms_temp != 0, 2'h0})
  endtask
  task automatic expect_out(input logic v);
    #1;
    `CHK(OUT_EN, v)
  endtask
  task automatic restart;
    @(posedge CLK);
    RESTART <= 1'b1;
    @(posedge CLK);
    RESTART <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask
  task automatic rises(input int cyc, output int r);
    logic prev;
    r = 0;
    prev = OUT_EN;
    repeat (cyc) begin
      @(posedge CLK);
      #1;
      if (OUT_EN && !prev) r++;
      prev = OUT_EN;
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    report_and_stop;
  end

  initial begin
    for (int i = 0; i < 8; i++) regs[CODES[i]] = DEFS[i];
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      i_host.rd(CODES[i], d, m);
      `CHK(d, regs[CODES[i]])
      set(CODES[i], seed[15:0]);
      seed = lfsr(seed);
      i_host.rd(CODES[i], d, m);
      `CHK(d, regs[CODES[i]])
      set(CODES[i], DEFS[i]);
    end
    i_host.rd(8'h60, d, m);
    `CHK({m, d}, 17'h10000)
    @(posedge CLK);
    ENABLE <= 1'b1;
    repeat (3) @(posedge CLK);
    expect_out(1'b1);
    temp(112);
    chk_status;
    temp(-45);
    chk_status;
    `CHK(ALERT_N, 1'b0)
    temp(20);
    clr;
    repeat (3) @(posedge CLK);
    chk_status;
    `CHK(ALERT_N, 1'b1)
    foreach (IL_SEQ[i]) il(IL_SEQ[i], i == 5);
    chk_status;
    il(14, 1'b0);
    chk_status;
    il(0, 1'b0);
    for (int i = 0; i < 3; i++) il(-14, 1'b0);
    chk_status;
    il(0, 1'b0);
    clr;
    @(posedge CLK);
    CONSEC_SAMPLES <= 4'h1;
    il(14, 1'b0);
    il(0, 1'b0);
    chk_status;
    set(8'h50, 16'h0000);
    temp(126);
    expect_out(1'b1);
    chk_status;
    temp(20);
    clr;
    set(8'h50, 16'h00c0);
    temp(126);
    expect_out(1'b0);
    temp(115);
    expect_out(1'b0);
    temp(100);
    expect_out(1'b1);
    set(8'h54, 16'h00c0);
    temp(-60);
    expect_out(1'b0);
    temp(-45);
    expect_out(1'b0);
    temp(-30);
    expect_out(1'b1);
    chk_status;
    clr;
    set(8'h50, 16'h0043);
    temp(126);
    expect_out(1'b1);
    for (k = 0; k < 40 && OUT_EN === 1'b1; k++) begin
      @(posedge CLK);
      #1;
    end
    `CHK(k inside {[8:16]}, 1'b1)
    temp(20);
    repeat (20) @(posedge CLK);
    expect_out(1'b0);
    restart;
    expect_out(1'b1);
    set(8'h50, 16'h0091);
    temp(126);
    expect_out(1'b0);
    rises(200, k);
    `CHK(k, 2)
    temp(20);
    restart;
    set(8'h50, 16'h00b9);
    temp(126);
    rises(200, k);
    `CHK(k > 6, 1'b1)
    @(posedge CLK);
    ENABLE <= 1'b0;
    @(posedge CLK);
    expect_out(1'b0);
    rises(20, k);
    `CHK(k, 0)
    temp(20);
    chk_status;
    report_and_stop;
  end
endmodule // tb
